// *** hw/dcg_gain_calc.sv ***
// Purpose: Turns the volume and trim codes into a mute flag and signed gains.
// Assumes: Codes are stable register outputs; the result is purely combinational.
// Notes:   The caller registers the results before they leave the block.
`timescale 1ns/1ps
`include "dcg_map.svh"

module dcg_gain_calc (
	// Codes held by the register bank
	input  wire dcg_pkg::dcg_byte_t      volume_code,
	input  wire dcg_pkg::dcg_trim_t      trim_code,
	// Decoded gain
	output logic                         mute,
	output dcg_pkg::dcg_half_db_t        coarse_half_db,
	output dcg_pkg::dcg_fine_t           fine_tenth_db,
	output dcg_pkg::dcg_tenth_db_t       total_tenth_db
);
	import dcg_pkg::*;

	dcg_tenth_db_t coarse_tenth;
	dcg_tenth_db_t fine_ext;

	always_comb begin
		// Code zero is a hard mute rather than a very large attenuation.
		mute           = (volume_code == `DCG_VOLUME_MUTE_CODE); // R1
		// Code 1 is -200 half steps (-100 dB), 2 is -99.5 dB, 201 is 0 dB, 255 is +27 dB.
		coarse_half_db = dcg_volume_half_db(volume_code); // R2 R3 R4 R12
		// Code 0 is -0.8 dB, 8 is 0 dB, 15 is +0.7 dB.
		fine_tenth_db  = dcg_trim_tenth_db(trim_code); // R6 R7 R12
		coarse_tenth   = dcg_tenth_db_t'(dcg_tenth_db_t'(coarse_half_db) * `DCG_TENTHS_PER_STEP);
		fine_ext       = dcg_tenth_db_t'(fine_tenth_db);
		total_tenth_db = dcg_tenth_db_t'(coarse_tenth + fine_ext); // R12
	end

endmodule

// *** hw/dcg_map.svh ***
// Purpose: Addresses, field positions, reset values and gain constants of the channel gain registers.
// Assumes: Byte-wide register space addressed by an 8-bit control port address.
// Notes:   Definitions only; included by the package and by the design modules.
`ifndef DCG_MAP_SVH
`define DCG_MAP_SVH

// Register addresses.
`define DCG_VOLUME_ADDR        8'h6e
`define DCG_TRIM_ADDR          8'h6f

// Reset values.
`define DCG_VOLUME_RESET       8'hc9
`define DCG_TRIM_RESET         8'h80
`define DCG_FULL_SCALE_RESET   1'b0
`define DCG_CM_TOL_RESET       1'b0

// Field layout of the fine-trim register.
`define DCG_TRIM_CODE_MSB      7
`define DCG_TRIM_CODE_LSB      4
`define DCG_TRIM_RSVD_MSB      3
`define DCG_TRIM_RSVD_LSB      0
`define DCG_TRIM_RSVD_VALUE    4'h0

// Gain law: volume in 0.5 dB steps, trim in 0.1 dB steps.
`define DCG_VOLUME_MUTE_CODE   8'h00
`define DCG_VOLUME_UNITY_CODE  10'sd201
`define DCG_TRIM_UNITY_CODE    6'sd8
`define DCG_TENTHS_PER_STEP    12'sd5

// Value read back from an address this block does not own.
`define DCG_UNMAPPED_READ      8'h00

`endif

// *** hw/dcg_pkg.sv ***
// Purpose: Types and shared gain arithmetic for the channel gain registers.
// Assumes: Constants come from dcg_map.svh.
// Notes:   Gains are signed counts of tenths (or halves) of a decibel.
`include "dcg_map.svh"

package dcg_pkg;

	typedef logic [7:0]         dcg_byte_t;
	typedef logic [3:0]         dcg_trim_t;
	typedef logic signed [9:0]  dcg_half_db_t;
	typedef logic signed [5:0]  dcg_fine_t;
	typedef logic signed [11:0] dcg_tenth_db_t;

	// Volume code to steps of 0.5 dB relative to unity.
	function automatic dcg_half_db_t dcg_volume_half_db(input dcg_byte_t code);
		dcg_half_db_t widened;
		widened = dcg_half_db_t'({2'b00, code});
		return dcg_half_db_t'(widened - `DCG_VOLUME_UNITY_CODE);
	endfunction

	// Trim code to steps of 0.1 dB relative to unity.
	function automatic dcg_fine_t dcg_trim_tenth_db(input dcg_trim_t code);
		dcg_fine_t widened;
		widened = dcg_fine_t'({2'b00, code});
		return dcg_fine_t'(widened - `DCG_TRIM_UNITY_CODE);
	endfunction

endpackage

// *** hw/dcg_regs.sv ***
// Purpose: Volume and fine-trim registers of one playback channel, with decoded gain and a muted sample path.
// Assumes: Single control port, synchronous inputs, one write or read per cycle each.
// Notes:   Analog selects are plain pins captured into flops; they have no address in this bank.
//
// Notes on behaviour
// R1: An eight-bit volume code is held; code zero mutes digital playback completely.
// R2: Volume code one is -100 dB, code two is -99.5 dB, half-dB steps.
// R3: Volume code 201 is unity gain, code 202 is +0.5 dB.
// R4: Volume code 254 is +26.5 dB and code 255 is +27 dB.
// R5: Volume register resets to 11001001b, unity gain.
// R6: Upper trim nibble gives 0.1 dB steps; code zero -0.8 dB, eight 0 dB.
// R7: Trim code fifteen is +0.7 dB; trim resets to 1000b.
// R8: Software writes zeros to low four trim bits; they read as zero.
// R9: Full-scale bit picks 2 or 4 Vrms; 4 Vrms needs 2.75 V reference.
// R10: Coupling bit clear gives limited common-mode tolerance; set gives rail-to-rail.
// R11: Volume sits at 0x6E, trim at 0x6F resetting to 0x80.
// R12: Intermediate codes map linearly: volume half dB, trim tenth dB, from unity.
`timescale 1ns/1ps
`include "dcg_map.svh"

module dcg_regs #(
	parameter int SAMPLE_W = 24
) (
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    reset,
	// Control port
	input  wire logic [7:0]              reg_addr,
	input  wire logic                    reg_wr_en,
	input  wire dcg_pkg::dcg_byte_t      reg_wr_data,
	input  wire logic                    reg_rd_en,
	output dcg_pkg::dcg_byte_t           reg_rd_data,
	output logic                         reg_rd_valid,
	// Channel-wide analog selects
	input  wire logic                    full_scale_select_in,
	input  wire logic                    common_mode_tolerance_select_in,
	output logic                         full_scale_select,
	output logic                         common_mode_tolerance_select,
	// Held codes and decoded gain
	output logic                         channel_mute,
	output dcg_pkg::dcg_byte_t           channel_volume_code,
	output dcg_pkg::dcg_trim_t           channel_fine_trim_code,
	output dcg_pkg::dcg_half_db_t        coarse_gain_half_db,
	output dcg_pkg::dcg_fine_t           fine_gain_tenth_db,
	output dcg_pkg::dcg_tenth_db_t       total_gain_tenth_db,
	// Playback samples
	input  wire logic [SAMPLE_W-1:0]     sample_in,
	input  wire logic                    sample_in_valid,
	output logic [SAMPLE_W-1:0]          sample_out,
	output logic                         sample_out_valid
);
	import dcg_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Register storage

	dcg_byte_t     volume_ff;
	dcg_trim_t     trim_ff;
	dcg_byte_t     rd_data_ff;
	logic          rd_valid_ff;
	logic          fs_sel_ff;
	logic          cm_tol_sel_ff;
	logic          mute_ff;
	dcg_half_db_t  coarse_ff;
	dcg_fine_t     fine_ff;
	dcg_tenth_db_t total_ff;
	logic [SAMPLE_W-1:0] sample_ff;
	logic          sample_valid_ff;

	logic          hit_volume;
	logic          hit_trim;
	dcg_byte_t     nxt_rd_data;
	logic          nxt_mute;
	dcg_half_db_t  nxt_coarse;
	dcg_fine_t     nxt_fine;
	dcg_tenth_db_t nxt_total;

	always_comb begin
		hit_volume = (reg_addr == `DCG_VOLUME_ADDR); // R11
		hit_trim   = (reg_addr == `DCG_TRIM_ADDR); // R11
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			volume_ff <= `DCG_VOLUME_RESET; // R5
		end else if (reg_wr_en && hit_volume) begin
			volume_ff <= reg_wr_data; // R1
		end
	end

	// Only the trim nibble is stored; the reserved nibble has no flops, so a stray write cannot stick.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			trim_ff <= dcg_trim_t'(`DCG_TRIM_RESET >> `DCG_TRIM_CODE_LSB); // R7 R11
		end else if (reg_wr_en && hit_trim) begin
			trim_ff <= reg_wr_data[`DCG_TRIM_CODE_MSB:`DCG_TRIM_CODE_LSB]; // R6
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	// A read in the same cycle as a write to the same address returns the old value.
	always_comb begin
		unique case (1'b1)
			hit_volume: nxt_rd_data = volume_ff;
			hit_trim:   nxt_rd_data = {trim_ff, `DCG_TRIM_RSVD_VALUE}; // R8
			default:    nxt_rd_data = `DCG_UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rd_data_ff  <= `DCG_UNMAPPED_READ;
			rd_valid_ff <= 1'b0;
		end else begin
			rd_valid_ff <= reg_rd_en;
			if (reg_rd_en) begin
				rd_data_ff <= nxt_rd_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Analog selects

	// These only steer analog trims; legality of the 4 Vrms range is left to software.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fs_sel_ff     <= `DCG_FULL_SCALE_RESET;
			cm_tol_sel_ff <= `DCG_CM_TOL_RESET;
		end else begin
			fs_sel_ff     <= full_scale_select_in;
			cm_tol_sel_ff <= common_mode_tolerance_select_in; // R10
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Gain decode

	dcg_gain_calc u_gain_calc (
		.volume_code    (volume_ff),
		.trim_code      (trim_ff),
		.mute           (nxt_mute),
		.coarse_half_db (nxt_coarse),
		.fine_tenth_db  (nxt_fine),
		.total_tenth_db (nxt_total)
	);

	// Reset values match the decode of the reset codes: unity gain, not muted.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mute_ff   <= 1'b0;
			coarse_ff <= '0;
			fine_ff   <= '0;
			total_ff  <= '0;
		end else begin
			mute_ff   <= nxt_mute; // R1
			coarse_ff <= nxt_coarse; // R2 R3 R4
			fine_ff   <= nxt_fine; // R6 R7
			total_ff  <= nxt_total; // R12
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sample path

	// Mute forces true zero, so no residue of the input leaks at code zero.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sample_ff       <= '0;
			sample_valid_ff <= 1'b0;
		end else begin
			sample_valid_ff <= sample_in_valid;
			if (sample_in_valid) begin
				sample_ff <= mute_ff ? '0 : sample_in; // R1
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_comb begin
		reg_rd_data                  = rd_data_ff;
		reg_rd_valid                 = rd_valid_ff;
		full_scale_select            = fs_sel_ff;
		common_mode_tolerance_select = cm_tol_sel_ff;
		channel_mute                 = mute_ff;
		channel_volume_code          = volume_ff;
		channel_fine_trim_code       = trim_ff;
		coarse_gain_half_db          = coarse_ff;
		fine_gain_tenth_db           = fine_ff;
		total_gain_tenth_db          = total_ff;
		sample_out                   = sample_ff;
		sample_out_valid             = sample_valid_ff;
	end

endmodule

// *** verif/dcg_regs_props.sv ***
// Purpose: Port-level checks of the channel gain register bank.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Coarse and fine gains are compared against the register codes one cycle earlier; total gain against the coarse and fine gains in the same cycle.
`timescale 1ns/1ps
module dcg_regs_props
	import dcg_pkg::*;
#(
	parameter int SAMPLE_W = 24
) (
	input wire logic                ref_clk,
	input wire logic                reset,
	input wire logic [7:0]          reg_addr,
	input wire logic                reg_wr_en,
	input wire dcg_pkg::dcg_byte_t  reg_wr_data,
	input wire logic                reg_rd_en,
	input wire dcg_pkg::dcg_byte_t  reg_rd_data,
	input wire logic                reg_rd_valid,
	input wire logic                full_scale_select_in,
	input wire logic                common_mode_tolerance_select_in,
	input wire logic                full_scale_select,
	input wire logic                common_mode_tolerance_select,
	input wire logic                channel_mute,
	input wire dcg_pkg::dcg_byte_t  channel_volume_code,
	input wire dcg_pkg::dcg_trim_t  channel_fine_trim_code,
	input wire dcg_pkg::dcg_half_db_t coarse_gain_half_db,
	input wire dcg_pkg::dcg_fine_t  fine_gain_tenth_db,
	input wire dcg_pkg::dcg_tenth_db_t total_gain_tenth_db,
	input wire logic [SAMPLE_W-1:0] sample_in,
	input wire logic                sample_in_valid,
	input wire logic [SAMPLE_W-1:0] sample_out,
	input wire logic                sample_out_valid
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////
	AST_MUTE: assert property (1'b1 |=> channel_mute == ($past(channel_volume_code) == 8'h00))
		else $error("mute flag wrong");
	AST_COARSE: assert property (1'b1 |=> coarse_gain_half_db == $signed({2'b00, $past(channel_volume_code)}) - 10'sd201)
		else $error("coarse gain wrong");
	AST_FINE: assert property (1'b1 |=> fine_gain_tenth_db == $signed({2'b00, $past(channel_fine_trim_code)}) - 6'sd8)
		else $error("fine gain wrong");
	AST_TOTAL: assert property (total_gain_tenth_db == coarse_gain_half_db * 12'sd5 + fine_gain_tenth_db)
		else $error("total gain wrong");
	AST_WR_VOL: assert property (reg_wr_en && reg_addr == 8'h6e |=> channel_volume_code == $past(reg_wr_data))
		else $error("volume write lost");
	AST_WR_TRIM: assert property (reg_wr_en && reg_addr == 8'h6f |=> channel_fine_trim_code == $past(reg_wr_data[7:4]))
		else $error("trim write lost");
	AST_RD_VALID: assert property (1'b1 |=> reg_rd_valid == $past(reg_rd_en))
		else $error("read valid wrong");
	AST_RD_TRIM: assert property (reg_rd_en && reg_addr == 8'h6f |=> reg_rd_data == {$past(channel_fine_trim_code), 4'h0})
		else $error("trim read wrong");
	AST_SAMPLE: assert property (sample_in_valid |=> sample_out_valid && sample_out == ($past(channel_mute) ? '0 : $past(sample_in)))
		else $error("sample path wrong");
	AST_SEL: assert property (1'b1 |=> common_mode_tolerance_select == $past(common_mode_tolerance_select_in))
		else $error("coupling select wrong");
	AST_FS: assert property (1'b1 |=> full_scale_select == $past(full_scale_select_in))
		else $error("full-scale select wrong");
	COV_MUTE: cover property (channel_mute && sample_out_valid);
	COV_MAX: cover property (channel_volume_code == 8'hff);
	COV_RD: cover property (reg_rd_en && reg_addr == 8'h6f);
endmodule
bind dcg_regs dcg_regs_props #(.SAMPLE_W(SAMPLE_W)) dcg_regs_props_inst (.*);

// *** verif/test_dcg_regs.sv ***
// Purpose: Self-checking bench of the channel gain register bank.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Random codes come from a fixed seed, mixed with the documented corner codes.
`timescale 1ns/1ps
module test_dcg_regs;
	import dcg_pkg::*;
	logic ref_clk, reset, reg_wr_en, reg_rd_en, reg_rd_valid, channel_mute, sample_in_valid, sample_out_valid;
	logic full_scale_select_in, common_mode_tolerance_select_in, full_scale_select, common_mode_tolerance_select;
	logic [7:0] reg_addr;
	dcg_byte_t reg_wr_data, reg_rd_data, channel_volume_code, v;
	dcg_trim_t channel_fine_trim_code, tr;
	dcg_half_db_t coarse_gain_half_db;
	dcg_fine_t fine_gain_tenth_db;
	dcg_tenth_db_t total_gain_tenth_db;
	logic [23:0] sample_in, sample_out, smp;
	dcg_byte_t vols [7] = '{8'h00, 8'h01, 8'h02, 8'hc9, 8'hca, 8'hfe, 8'hff};
	dcg_trim_t trims [3] = '{4'h0, 4'h8, 4'hf};
	int num_errors = 0;
	int cmp_count = 0;
	int k;
	dcg_regs #(.SAMPLE_W(24)) dcg_regs_inst (.*);
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk_val(input logic signed [23:0] got, input logic signed [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc;
		@(posedge ref_clk);
		#1;
	endtask
	// Expected gains follow the linear law around the unity codes 201 and 8.
	function automatic logic signed [23:0] exp_coarse(input dcg_byte_t code);
		return 24'(int'(code) - 201);
	endfunction
	function automatic logic signed [23:0] exp_fine(input dcg_trim_t code);
		return 24'(int'(code) - 8);
	endfunction
	function automatic logic signed [23:0] exp_total(input dcg_byte_t code, input dcg_trim_t trim);
		return 24'(exp_coarse(code) * 5 + exp_fine(trim));
	endfunction
	task automatic wr(input logic [7:0] a, input dcg_byte_t d);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		cyc;
		reg_wr_en = 1'b0;
		cyc;
	endtask
	// The valid pulse stands one cycle, so the wait is short and bounded.
	task automatic rd(input logic [7:0] a, input dcg_byte_t exp);
		int n;
		reg_addr = a;
		reg_rd_en = 1'b1;
		cyc;
		reg_rd_en = 1'b0;
		for (n = 0; n < 3 && reg_rd_valid !== 1'b1; n++) cyc;
		if (n == 3) begin
			num_errors++;
			$display("CHECK FAILED t=%0t read valid missing", $time);
			print_verdict;
		end
		chk_val(reg_rd_data, exp);
		cyc;
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{reset, reg_wr_en, reg_rd_en, sample_in_valid} = 4'h8;
		{full_scale_select_in, common_mode_tolerance_select_in, reg_addr, reg_wr_data, sample_in} = '0;
		void'($urandom(10718));
		repeat (8) cyc;
		reset = 1'b0;
		chk_val(total_gain_tenth_db, 0);
		chk_val(channel_volume_code, 8'hc9);
		chk_val(channel_fine_trim_code, 4'h8);
		chk_val(channel_mute, 0);
		rd(8'h6e, 8'hc9);
		rd(8'h6f, 8'h80);
		$display("test reset done");
		for (k = 0; k < 16; k++) begin
			v = (k < 7) ? vols[k] : 8'($urandom);
			tr = (k < 3) ? trims[k] : 4'($urandom);
			wr(8'h6e, v);
			wr(8'h6f, {tr, 4'h0});
			wr(8'($urandom_range(8'h70, 8'hff)), 8'($urandom));
			cyc;
			chk_val(channel_mute, v == 8'h00);
			chk_val(channel_volume_code, v);
			chk_val(channel_fine_trim_code, tr);
			chk_val(coarse_gain_half_db, exp_coarse(v));
			chk_val(fine_gain_tenth_db, exp_fine(tr));
			chk_val(total_gain_tenth_db, exp_total(v, tr));
			rd(8'h6e, v);
			rd(8'h6f, {tr, 4'h0});
			rd(8'($urandom_range(8'h00, 8'h6d)), 8'h00);
		end
		$display("test gain codes done");
		for (k = 0; k < 8; k++) begin
			v = k[0] ? 8'($urandom) | 8'h01 : 8'h00;
			wr(8'h6e, v);
			cyc;
			smp = 24'($urandom);
			sample_in = smp;
			sample_in_valid = 1'b1;
			{full_scale_select_in, common_mode_tolerance_select_in} = 2'($urandom);
			cyc;
			sample_in_valid = 1'b0;
			chk_val(sample_out, k[0] ? smp : 24'h00_0000);
			chk_val(sample_out_valid, 1);
			chk_val({full_scale_select, common_mode_tolerance_select}, {full_scale_select_in, common_mode_tolerance_select_in});
		end
		$display("test sample path done");
		wr(8'h6f, 8'h30);
		wr(8'h6e, 8'h00);
		reset = 1'b1;
		cyc;
		cyc;
		reset = 1'b0;
		chk_val(channel_volume_code, 8'hc9);
		chk_val(channel_fine_trim_code, 4'h8);
		chk_val(channel_mute, 0);
		rd(8'h6f, 8'h80);
		$display("test mid-run reset done");
		print_verdict;
	end
endmodule
